/* hdl/nvm_access_dev.sv */
/*
 nonvolatile configuration-area access logic: table fetch into the lookup
 latch with cpu stall, and gated programming with fault tracking.
 assumes the cpu end drives the link synchronously to pclk; the
 interrupting resets arrive as synchronous pulses from the reset block.
// Summary of operation
// - area codes 01 or 11 route config accesses
// - pointer then fetch puts byte in latch
// - stall cpu until latch is loaded
// - out-of-range fetch clears latch to zero
// - reset during programming sets fault flag
// - go ignored unless unlock enable set
// - software unlocks before every program operation
// - hardware never clears unlock enable itself
// - software keeps unlock enable clear normally
// - software verifies page against ram copy
// - software rechecks location after interrupted write
*/
// Design decisions made here: register access over APB and the placing of the registers.
`default_nettype none
`include "nvm_access_defs.svh"
module nvm_access_dev #(
   parameter int STORE_DEPTH = 16,
   parameter int STORE_IW = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // interrupting resets, one-cycle pulses
   input wire logic master_clear_reset,
   input wire logic watchdog_timeout,
   // link to the cpu end
   nvm_access_if.dev link
);
   typedef struct packed {
      nvm_access_pkg::dev_state_e state;
      logic [7:0] count;
      logic [7:0] latch;
      logic stall;
      logic busy;
      logic fault;
      logic [1:0] keys;
      logic [STORE_IW-1:0] idx;
      logic [7:0] wbyte;
   } state_s;

   state_s cur, nxt;
   logic [7:0] store_rdata;
   logic store_wr;

   function automatic logic area_ok(input nvm_access_pkg::area_t a);
      return a == `AREA_CFG_A || a == `AREA_CFG_B;
   endfunction

   function automatic logic addr_ok(input nvm_access_pkg::addr_t p);
      return p >= `CFG_LO && p <= `CFG_HI &&
         (p - `CFG_LO) < `PTR_W'(STORE_DEPTH);
   endfunction

   cfg_area_store #(.DEPTH(STORE_DEPTH), .IW(STORE_IW)) u_store (
      .pclk(pclk),
      .presetn(presetn),
      .idx(cur.idx),
      .wr(store_wr),
      .wdata(cur.wbyte),
      .rdata(store_rdata)
   );

   always_comb begin
      nxt = cur;
      store_wr = 1'b0;
      // unlock sequence: two keys in order, one arm per program operation
      if (link.unlock_key_strobe) begin
         if (link.unlock_key == `UNLOCK_KEY1) begin
            nxt.keys = 2'h1;
         end else if (link.unlock_key == `UNLOCK_KEY2 && cur.keys == 2'h1) begin
            nxt.keys = 2'h3;
         end else begin
            nxt.keys = 2'h0;
         end
      end
      case (cur.state)
         nvm_access_pkg::st_idle: begin
            if (link.lookup_fetch_op) begin
               nxt.state = nvm_access_pkg::st_fetch;
               nxt.stall = 1'b1;
               nxt.count = 8'(`FETCH_CYCLES);
               nxt.idx = STORE_IW'(link.lookup_pointer - `CFG_LO);
            end else if (link.program_go && link.program_unlock_enable
                  && cur.keys == 2'h3 && area_ok(link.area_select)
                  && addr_ok(link.lookup_pointer)) begin
               nxt.state = nvm_access_pkg::st_prog;
               nxt.busy = 1'b1;
               nxt.keys = 2'h0;
               nxt.count = `PROG_CYCLES;
               nxt.idx = STORE_IW'(link.lookup_pointer - `CFG_LO);
               nxt.wbyte = link.program_data;
            end
         end
         nvm_access_pkg::st_fetch: begin
            if (cur.count == 8'h1) begin
               // address held stable by the stalled cpu
               if (area_ok(link.area_select) && addr_ok(link.lookup_pointer))
               begin
                  nxt.latch = store_rdata;
               end else begin
                  nxt.latch = 8'h00;
               end
               nxt.stall = 1'b0;
               nxt.state = nvm_access_pkg::st_idle;
            end else begin
               nxt.count = cur.count - 8'h1;
            end
         end
         nvm_access_pkg::st_prog: begin
            if (master_clear_reset || watchdog_timeout) begin
               // write is aborted; the cell is left untouched
               nxt.fault = 1'b1;
               nxt.busy = 1'b0;
               nxt.state = nvm_access_pkg::st_idle;
            end else if (cur.count == 8'h1) begin
               store_wr = 1'b1;
               nxt.busy = 1'b0;
               nxt.state = nvm_access_pkg::st_idle;
            end else begin
               nxt.count = cur.count - 8'h1;
            end
         end
         default: begin
            nxt.state = nvm_access_pkg::st_idle;
         end
      endcase
      // set wins over a same-cycle clear
      if (link.fault_clear && !(cur.state == nvm_access_pkg::st_prog
            && (master_clear_reset || watchdog_timeout))) begin
         nxt.fault = 1'b0;
      end
   end

   // the interrupting resets act through the logic above, not presetn,
   // so the fault flag survives them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= nxt;
      end
   end

   // unlock enable is an input only and is never written here
   assign link.lookup_latch = cur.latch;
   assign link.cpu_stall = cur.stall;
   assign link.program_busy = cur.busy;
   assign link.program_fault_flag = cur.fault;
endmodule
`default_nettype wire

/* shared/nvm_access_defs.svh */
/*
 constants for the configuration-area access link: area codes, address
 window limits, widths and timing counts. assumes inclusion by bare name.
*/
`ifndef NVM_ACCESS_DEFS_SVH
`define NVM_ACCESS_DEFS_SVH

`define AREA_SEL_W 2
`define AREA_CFG_A 2'h1
`define AREA_CFG_B 2'h3
`define PTR_W 22
`define CFG_LO 22'h200000
`define CFG_HI 22'h3fffff
`define FETCH_CYCLES 4'h3
`define PROG_CYCLES 8'h20
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'haa

`define REG_CTRL 12'h000
`define REG_PTR 12'h004
`define REG_LATCH 12'h008
`define REG_STATUS 12'h00c
`define REG_UNLOCK 12'h010
`define CTRL_FETCH_BIT 0
`define CTRL_GO_BIT 1
`define CTRL_UNLOCK_EN_BIT 2
`define CTRL_FAULT_CLR_BIT 3
`define CTRL_AREA_LSB 4

`endif

/* shared/nvm_access_pkg.sv */
/*
 types used by the device end of the configuration-area access link.
 assumes nvm_access_defs.svh is on the include path.
*/
`default_nettype none
`include "nvm_access_defs.svh"
package nvm_access_pkg;
   typedef logic [`PTR_W-1:0] addr_t;
   typedef logic [`AREA_SEL_W-1:0] area_t;
   typedef enum logic [2:0] {
      st_idle, st_fetch, st_prog
   } dev_state_e;
endpackage
`default_nettype wire

/* shared/nvm_access_if.sv */
/*
 link between the cpu-side controller and the nonvolatile access logic.
 assumes a single clock domain driven by the bench.
*/
`default_nettype none
`include "nvm_access_defs.svh"
interface nvm_access_if;
   logic [`AREA_SEL_W-1:0] area_select;
   logic [`PTR_W-1:0] lookup_pointer;
   logic lookup_fetch_op;
   logic [7:0] lookup_latch;
   logic cpu_stall;
   logic program_unlock_enable;
   logic program_go;
   logic [7:0] unlock_key;
   logic unlock_key_strobe;
   logic [7:0] program_data;
   logic program_busy;
   logic program_fault_flag;
   logic fault_clear;
   modport dev (
      input area_select, lookup_pointer, lookup_fetch_op,
      input program_unlock_enable, program_go, unlock_key,
      input unlock_key_strobe, program_data, fault_clear,
      output lookup_latch, cpu_stall, program_busy, program_fault_flag
   );
   modport cpu (
      output area_select, lookup_pointer, lookup_fetch_op,
      output program_unlock_enable, program_go, unlock_key,
      output unlock_key_strobe, program_data, fault_clear,
      input lookup_latch, cpu_stall, program_busy, program_fault_flag
   );
endinterface
`default_nettype wire

/* hdl/cfg_area_store.sv */
/*
 small flip-flop store standing in for the configuration areas; one byte
 per index, read combinationally, written by the device on program end.
 assumes the caller bounds the index to the store depth.
*/
`default_nettype none
module cfg_area_store #(
   parameter int DEPTH = 16,
   parameter int IW = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // access
   input wire logic [IW-1:0] idx,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];

   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_cell
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem[i] <= 8'hff;
            end else if (wr && idx == IW'(i)) begin
               mem[i] <= wdata;
            end
         end
      end
   endgenerate

   assign rdata = mem[idx];
endmodule
`default_nettype wire

/* hdl/nvm_access_cpu.sv */
/*
 cpu end: an apb slave whose registers drive the access link.
 assumes the apb master and the device end share pclk.
*/
`default_nettype none
`include "nvm_access_defs.svh"
module nvm_access_cpu (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link to the device end
   nvm_access_if.cpu link
);
   typedef struct packed {
      logic [`AREA_SEL_W-1:0] area;
      logic [`PTR_W-1:0] ptr;
      logic fetch;
      logic go;
      logic unlock_en;
      logic fault_clr;
      logic [7:0] key;
      logic key_stb;
      logic [7:0] data;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } state_s;

   state_s cur, nxt;
   logic access;

   always_comb begin
      nxt = cur;
      nxt.fetch = 1'b0;
      nxt.go = 1'b0;
      nxt.fault_clr = 1'b0;
      nxt.key_stb = 1'b0;
      nxt.ready = 1'b0;
      nxt.err = 1'b0;
      access = psel && penable && !cur.ready && !link.cpu_stall;
      if (access) begin
         nxt.ready = 1'b1;
         nxt.rdata = 32'h0;
         if (pwrite) begin
            case (paddr)
               `REG_CTRL: begin
                  nxt.fetch = pwdata[`CTRL_FETCH_BIT];
                  nxt.go = pwdata[`CTRL_GO_BIT];
                  nxt.unlock_en = pwdata[`CTRL_UNLOCK_EN_BIT];
                  nxt.fault_clr = pwdata[`CTRL_FAULT_CLR_BIT];
                  nxt.area = pwdata[`CTRL_AREA_LSB +: `AREA_SEL_W];
               end
               `REG_PTR: nxt.ptr = pwdata[`PTR_W-1:0];
               `REG_LATCH: nxt.data = pwdata[7:0];
               `REG_UNLOCK: begin
                  nxt.key = pwdata[7:0];
                  nxt.key_stb = 1'b1;
               end
               default: nxt.err = 1'b1;
            endcase
         end else begin
            case (paddr)
               `REG_CTRL: begin
                  nxt.rdata[`CTRL_UNLOCK_EN_BIT] = cur.unlock_en;
                  nxt.rdata[`CTRL_AREA_LSB +: `AREA_SEL_W] = cur.area;
               end
               `REG_PTR: nxt.rdata[`PTR_W-1:0] = cur.ptr;
               `REG_LATCH: nxt.rdata[7:0] = link.lookup_latch;
               `REG_STATUS: nxt.rdata[2:0] = {link.cpu_stall,
                  link.program_busy, link.program_fault_flag};
               `REG_UNLOCK: nxt.rdata = 32'h0;
               default: nxt.err = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= nxt;
      end
   end

   assign prdata = cur.rdata;
   assign pready = cur.ready;
   assign pslverr = cur.err;
   assign link.area_select = cur.area;
   assign link.lookup_pointer = cur.ptr;
   assign link.lookup_fetch_op = cur.fetch;
   assign link.program_go = cur.go;
   assign link.program_unlock_enable = cur.unlock_en;
   assign link.fault_clear = cur.fault_clr;
   assign link.unlock_key = cur.key;
   assign link.unlock_key_strobe = cur.key_stb;
   assign link.program_data = cur.data;
endmodule
`default_nettype wire

/* tb/nvm_access_sva.sv */
/*
 assertions on the link between the cpu end and the access logic.
 assumes the bench instantiates it beside the link, on pclk.
*/
`default_nettype none
`include "nvm_access_defs.svh"
module nvm_access_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link and interrupting resets
   input wire logic [1:0] area_select,
   input wire logic [21:0] lookup_pointer,
   input wire logic lookup_fetch_op,
   input wire logic [7:0] lookup_latch,
   input wire logic cpu_stall,
   input wire logic program_unlock_enable,
   input wire logic program_go,
   input wire logic program_busy,
   input wire logic program_fault_flag,
   input wire logic fault_clear,
   input wire logic master_clear_reset,
   input wire logic watchdog_timeout
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic idle;
   logic outside;
   logic area_ok;
   assign idle = !cpu_stall && !program_busy;
   // pointer test only: store depth is the default of sixteen bytes
   assign outside = lookup_pointer < `CFG_LO ||
      lookup_pointer > `CFG_LO + 22'hf;
   assign area_ok = area_select == `AREA_CFG_A ||
      area_select == `AREA_CFG_B;
   sequence fetch_start;
      lookup_fetch_op && idle;
   endsequence
   sequence stall_run;
      cpu_stall [*3] ##1 !cpu_stall;
   endsequence
   a_stall_span: assert property (fetch_start |=> stall_run)
      else $error("stall length wrong");
   a_latch_zero: assert property ((fetch_start and outside) ##1
      stall_run |-> lookup_latch == 8'h00) else $error("latch not zero");
   a_latch_moves: assert property ($changed(lookup_latch)
      |-> $fell(cpu_stall)) else $error("latch moved outside fetch");
   a_go_gated: assert property (program_go && !program_unlock_enable
      && idle |=> !program_busy) else $error("go taken while locked");
   a_area_gate: assert property (program_go && idle && !area_ok
      |=> !program_busy) else $error("go taken in wrong area");
   a_fault_set: assert property (program_busy && (master_clear_reset
      || watchdog_timeout) |=> program_fault_flag && !program_busy)
      else $error("abort not flagged");
   a_fault_hold: assert property (program_fault_flag && !fault_clear
      |=> program_fault_flag) else $error("fault flag dropped");
   a_busy_bound: assert property ($rose(program_busy)
      |-> ##[1:32] !program_busy) else $error("programming too long");
endmodule
`default_nettype wire

/* tb/config_area_nvm_access_tb.sv */
/*
 testbench: apb tasks drive the cpu end, which faces the access logic.
 assumes the register map and timing of the shared defines.
*/
`default_nettype none
`include "nvm_access_defs.svh"
module config_area_nvm_access_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic master_clear_reset, watchdog_timeout;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   int errors, cmp_count;
   nvm_access_if link();
   nvm_access_dev u_nvm_access_dev (.pclk, .presetn, .master_clear_reset,
      .watchdog_timeout, .link(link));
   nvm_access_cpu u_nvm_access_cpu (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
   nvm_access_sva u_sva (.pclk, .presetn, .master_clear_reset,
      .watchdog_timeout, .area_select(link.area_select),
      .lookup_pointer(link.lookup_pointer), .cpu_stall(link.cpu_stall),
      .lookup_fetch_op(link.lookup_fetch_op), .program_go(link.program_go),
      .lookup_latch(link.lookup_latch), .fault_clear(link.fault_clear),
      .program_unlock_enable(link.program_unlock_enable),
      .program_busy(link.program_busy),
      .program_fault_flag(link.program_fault_flag));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic report_and_stop;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // the access may stretch while the cpu is stalled, so wait on pready
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 99);
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 99) begin
         errors++;
         report_and_stop;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e,
      input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdat);
   endtask
   task automatic fetch(input logic [21:0] p, input logic [7:0] e,
      input string nm);
      wr(`REG_PTR, {10'h0, p});
      wr(`REG_CTRL, 32'h11);
      rdc(`REG_LATCH, {24'h0, e}, nm);
   endtask
   task automatic prog(input logic [21:0] p, input logic [7:0] d,
      input logic [31:0] c);
      wr(`REG_PTR, {10'h0, p});
      wr(`REG_LATCH, {24'h0, d});
      wr(`REG_UNLOCK, {24'h0, `UNLOCK_KEY1});
      wr(`REG_UNLOCK, {24'h0, `UNLOCK_KEY2});
      wr(`REG_CTRL, c);
   endtask
   task automatic idle_wait;
      int n;
      n = 0;
      do begin
         apb(1'b0, `REG_STATUS, 32'h0);
         n++;
      end while (rdat[1] !== 1'b0 && n < 30);
      if (n >= 30) begin
         errors++;
         report_and_stop;
      end
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      master_clear_reset = 1'b0;
      watchdog_timeout = 1'b0;
      errors = 0;
      cmp_count = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`REG_STATUS, 32'h0, "status");
      apb(1'b0, 12'h014, 32'h0);
      chk("slverr", 32'h1, {31'h0, serr});
      fetch(`CFG_LO, 8'hff, "first byte");
      wr(`REG_CTRL, 32'h31);
      rdc(`REG_LATCH, 32'hff, "area three");
      wr(`REG_CTRL, 32'h21);
      rdc(`REG_LATCH, 32'h0, "area two read");
      fetch(`CFG_LO - 22'h1, 8'h00, "below");
      fetch(`CFG_LO + 22'h10, 8'h00, "past store");
      prog(`CFG_LO, 8'h5a, 32'h12);
      rdc(`REG_STATUS, 32'h0, "locked go");
      prog(`CFG_LO, 8'h5a, 32'h26);
      rdc(`REG_STATUS, 32'h0, "area two go");
      prog(`CFG_LO + 22'h1, 8'h5a, 32'h16);
      rdc(`REG_STATUS, 32'h2, "busy");
      idle_wait;
      rdc(`REG_CTRL, 32'h14, "unlock kept");
      wr(`REG_CTRL, 32'h16);
      rdc(`REG_STATUS, 32'h0, "no fresh keys");
      wr(`REG_CTRL, 32'h10);
      rdc(`REG_CTRL, 32'h10, "unlock off");
      fetch(`CFG_LO + 22'h1, 8'h5a, "stored");
      for (int k = 0; k < 2; k++) begin
         prog(`CFG_LO + 22'h2, 8'h33, 32'h16);
         @(posedge pclk);
         master_clear_reset <= k[0];
         watchdog_timeout <= !k[0];
         @(posedge pclk);
         master_clear_reset <= 1'b0;
         watchdog_timeout <= 1'b0;
         rdc(`REG_STATUS, 32'h1, "fault");
         repeat (40) @(posedge pclk);
         rdc(`REG_STATUS, 32'h1, "fault held");
         fetch(`CFG_LO + 22'h2, 8'hff, "not stored");
         wr(`REG_CTRL, 32'h08);
         rdc(`REG_STATUS, 32'h0, "cleared");
      end
      report_and_stop;
   end
endmodule
`default_nettype wire
